// ==== inc/capture_pkg.sv ====
// shared constants and types for the acquisition buffer controller
package capture_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  localparam logic [3:0]  CTRL_ADDR       = 4'h0;
  localparam logic [3:0]  DEPTH_ADDR      = 4'h1;
  localparam logic [3:0]  SEGS_ADDR       = 4'h2;
  localparam logic [3:0]  CUSTPOS_ADDR    = 4'h3;
  localparam logic [3:0]  STATUS_ADDR     = 4'h4;
  localparam logic [3:0]  TRIGADDR_ADDR   = 4'h5;
  localparam logic [3:0]  WRPTR_ADDR      = 4'h6;
  localparam logic [3:0]  MEMRD_ADDR      = 4'h7;

  // ctrl fields
  localparam int          CTRL_ARM_BIT    = 0;
  localparam int          CTRL_SEG_BIT    = 1;
  localparam int          CTRL_POS_LSB    = 2;
  localparam int          CTRL_QUAL_BIT   = 4;
  localparam int          CTRL_STOP_BIT   = 5;

  // status fields
  localparam int          STAT_ACTIVE_BIT = 0;
  localparam int          STAT_DONE_BIT   = 1;
  localparam int          STAT_TRIG_BIT   = 2;
  localparam int          STAT_SEG_LSB    = 8;

  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] SEGS_RESET      = 32'h0000_0001;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    POS_PRE    = 2'b00,
    POS_CENTER = 2'b01,
    POS_POST   = 2'b10,
    POS_CUSTOM = 2'b11
  } trig_pos_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_POST = 2'b11,
    ST_DONE = 2'b10
  } acq_state_e;

endpackage

// ==== inc/capture_mem_if.sv ====
// write and read port bundle between controller and sample memory
`timescale 1ns/1ps
interface capture_mem_if #(
  parameter int AW = 17,
  parameter int SW = 32
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [SW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [SW-1:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ==== hw/capture_ram.sv ====
// dedicated sample memory of the acquisition buffer
`timescale 1ns/1ps
module capture_ram #(
  parameter int AW = 17,
  parameter int SW = 32
) (
  input  wire logic   clk_in,
  capture_mem_if.mem  port_if
);

  // ****************************************************************
  // storage
  // ****************************************************************
  // no other port: the array belongs to the analyzer alone
  logic [SW-1:0] mem_array [2**AW]; // R17
  logic [SW-1:0] rd_data_reg;

  always_ff @(posedge clk_in) begin
    if (port_if.wr_en) begin
      mem_array[port_if.wr_addr] <= port_if.wr_data;
    end
    rd_data_reg <= mem_array[port_if.rd_addr];
  end

  assign port_if.rd_data = rd_data_reg;

endmodule

// ==== hw/capture_ctrl.sv ====
// acquisition buffer controller: circular and segmented capture
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps

// Summary of operation
// R1: sample depth configurable from zero up to 128K entries.
// R2: memory runs either as one circular buffer or as segments.
// R3: non-segmented buffer fills continuously until the trigger.
// R4: once full without trigger, new samples overwrite the oldest.
// R5: post placement stops soon after trigger; most samples precede it.
// R6: pre placement keeps writing; most samples follow the trigger.
// R7: center placement puts trigger mid-window.
// R8: non-segmented circular mode is the reset default.
// R9: segments are equal and each acts as a circular buffer.
// R10: only one segment takes samples at a time.
// R11: after active segment completes, next segment becomes active.
// R12: each segment has its own trigger, evaluated while active.
// R13: segment count configurable; memory split equally among them.
// R14: per-segment triggers come only from the state-based trigger flow.
// R15: custom trigger position from state-based logic replaces presets.
// R16: in non-segmented mode a qualifier gates each sample write.
// R17: the sample RAM is used only by the analyzer.
// R18: without qualifier, one sample written every sampling cycle.
// R19: observed logic drives qualifier high to store, low to skip.
// R20: trigger sample address recorded per segment.
// R21: after last post-trigger sample, stop and flag done until rearmed.
module capture_ctrl
  import capture_pkg::*;
#(
  parameter int SAMPLE_W  = 32,
  parameter int MAX_DEPTH = 131072,
  parameter int MAX_SEGS  = 64
) (
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  input  wire logic [ADDR_W-1:0]   addr_in,
  input  wire logic [DATA_W-1:0]   wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic      [DATA_W-1:0]   rdata_out,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  input  wire logic                trigger_in,
  input  wire logic                seg_trigger_in,
  input  wire logic                qualifier_in,
  output logic                     acq_done_out,
  output logic                     acq_active_out,
  output logic [$clog2(MAX_SEGS)-1:0] seg_index_out
);

  localparam int AW = $clog2(MAX_DEPTH);
  localparam int GW = $clog2(MAX_SEGS) > 0 ? $clog2(MAX_SEGS) : 1;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (MAX_DEPTH < 2 || MAX_DEPTH > 131072 || (MAX_DEPTH & (MAX_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("MAX_DEPTH must be a power of two from 2 to 131072");
  end
  if (MAX_SEGS < 2 || (MAX_SEGS & (MAX_SEGS - 1)) != 0 || MAX_SEGS > MAX_DEPTH) begin : g_bad_segs
    $error("MAX_SEGS must be a power of two from 2 up to MAX_DEPTH");
  end

  // ****************************************************************
  // functions
  // ****************************************************************
  // samples wanted after trigger for a window of len entries
  function automatic logic [AW:0] post_count(input trig_pos_e pos, input logic [AW:0] len,
                                             input logic [AW:0] cust);
    logic [AW:0] r;
    r = '0;
    case (pos)
      POS_PRE:    r = len - (len >> 3);                  // R6
      POS_CENTER: r = len >> 1;                          // R7
      POS_POST:   r = len >> 3;                          // R5
      POS_CUSTOM: r = (cust < len) ? cust : len;         // R15
      default:    r = len >> 1;
    endcase
    return r;
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    return a == r;
  endfunction

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [DATA_W-1:0] ctrl_reg, ctrl_next;
  logic [AW:0]       depth_reg, depth_next;
  logic [GW:0]       segs_reg, segs_next;
  logic [AW:0]       custpos_reg, custpos_next;
  logic              arm_pulse;
  logic              stop_pulse;

  always_comb begin
    ctrl_next    = ctrl_reg;
    depth_next   = depth_reg;
    segs_next    = segs_reg;
    custpos_next = custpos_reg;
    arm_pulse    = 1'b0;
    stop_pulse   = 1'b0;
    if (wr_in && reg_hit(addr_in, CTRL_ADDR)) begin
      ctrl_next  = wdata_in;
      arm_pulse  = wdata_in[CTRL_ARM_BIT];
      stop_pulse = wdata_in[CTRL_STOP_BIT];
      ctrl_next[CTRL_ARM_BIT]  = 1'b0;
      ctrl_next[CTRL_STOP_BIT] = 1'b0;
    end
    if (wr_in && reg_hit(addr_in, DEPTH_ADDR)) begin
      // depth 0..MAX_DEPTH
      depth_next = (wdata_in > DATA_W'(MAX_DEPTH)) ? (AW+1)'(MAX_DEPTH) : wdata_in[AW:0]; // R1
    end
    if (wr_in && reg_hit(addr_in, SEGS_ADDR)) begin
      segs_next = (wdata_in == '0) ? (GW+1)'(1) :
                  (wdata_in > DATA_W'(MAX_SEGS)) ? (GW+1)'(MAX_SEGS) : wdata_in[GW:0]; // R13
    end
    if (wr_in && reg_hit(addr_in, CUSTPOS_ADDR)) begin
      custpos_next = wdata_in[AW:0];
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_reg    <= CTRL_RESET; // R8
      depth_reg   <= (AW+1)'(MAX_DEPTH);
      segs_reg    <= SEGS_RESET[GW:0];
      custpos_reg <= '0;
    end else begin
      ctrl_reg    <= ctrl_next;
      depth_reg   <= depth_next;
      segs_reg    <= segs_next;
      custpos_reg <= custpos_next;
    end
  end

  wire       seg_mode = ctrl_reg[CTRL_SEG_BIT]; // R2
  wire       qual_en  = ctrl_reg[CTRL_QUAL_BIT] && !seg_mode; // R16
  trig_pos_e pos_sel;
  assign pos_sel = trig_pos_e'(ctrl_reg[CTRL_POS_LSB +: 2]);

  // segment length: depth divided equally by the segment count in use (one when not segmented)
  logic [AW:0] seg_len;
  logic [GW:0] seg_cnt;
  assign seg_cnt = seg_mode ? segs_reg : (GW+1)'(1);
  assign seg_len = depth_reg / seg_cnt; // R9 R13

  // ****************************************************************
  // input synchronisers for probe-side pins
  // ****************************************************************
  logic [2:0] sync1_reg, sync2_reg;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {qualifier_in, seg_trigger_in, trigger_in};
      sync2_reg <= sync1_reg;
    end
  end
  wire trig_s = sync2_reg[0];
  wire segtrig_s = sync2_reg[1];
  wire qual_s = sync2_reg[2];
  // sample data delayed to stay aligned with the synchronised controls
  logic [SAMPLE_W-1:0] samp1_reg, samp2_reg;
  always_ff @(posedge clk_in) begin
    samp1_reg <= sample_in;
    samp2_reg <= samp1_reg;
  end

  // ****************************************************************
  // acquisition state machine
  // ****************************************************************
  acq_state_e  state_reg, state_next;
  logic [AW-1:0] base_reg, base_next;
  logic [AW:0]   off_reg, off_next;
  logic [AW:0]   post_reg, post_next;
  logic [GW-1:0] seg_reg, seg_next;
  logic          trig_seen_reg, trig_seen_next;
  logic [AW-1:0] trig_addr_reg [MAX_SEGS];
  logic          rec_trig;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic          seg_trig;
  logic          store;

  // per-segment trigger from state-based flow in segmented mode
  assign seg_trig = seg_mode ? segtrig_s : trig_s; // R12 R14
  // qualifier: high stores, low skips
  assign store    = qual_en ? qual_s : 1'b1; // R18 R19
  assign wr_addr  = base_reg + off_reg[AW-1:0];

  always_comb begin
    state_next     = state_reg;
    base_next      = base_reg;
    off_next       = off_reg;
    post_next      = post_reg;
    seg_next       = seg_reg;
    trig_seen_next = trig_seen_reg;
    wr_en          = 1'b0;
    rec_trig       = 1'b0;
    case (state_reg)
      ST_IDLE, ST_DONE: begin
        if (arm_pulse) begin
          state_next     = (seg_len == '0) ? ST_DONE : ST_FILL;
          base_next      = '0;
          off_next       = '0;
          seg_next       = '0;
          trig_seen_next = 1'b0;
        end
      end
      ST_FILL: begin
        if (store) begin
          wr_en = 1'b1; // R3 R10
          off_next = (off_reg + 1'b1 == seg_len) ? '0 : off_reg + 1'b1; // R4
          if (seg_trig) begin
            rec_trig       = 1'b1; // R20
            trig_seen_next = 1'b1;
            post_next      = post_count(pos_sel, seg_len, custpos_reg);
            if (post_count(pos_sel, seg_len, custpos_reg) <= (AW+1)'(1)) begin
              state_next = ST_POST;
              post_next  = '0;
            end else begin
              state_next = ST_POST;
              post_next  = post_count(pos_sel, seg_len, custpos_reg) - 1'b1;
            end
          end
        end
      end
      ST_POST: begin
        if (post_reg == '0) begin
          // segment complete: next segment or finish
          if (seg_mode && (GW+1)'(seg_reg) + 1'b1 < seg_cnt) begin
            seg_next   = seg_reg + 1'b1; // R11
            base_next  = base_reg + seg_len[AW-1:0];
            off_next   = '0;
            state_next = ST_FILL;
          end else begin
            state_next = ST_DONE; // R21
          end
        end else if (store) begin
          wr_en     = 1'b1;
          off_next  = (off_reg + 1'b1 == seg_len) ? '0 : off_reg + 1'b1;
          post_next = post_reg - 1'b1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (stop_pulse) begin
      state_next = ST_DONE;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg     <= ST_IDLE;
      base_reg      <= '0;
      off_reg       <= '0;
      post_reg      <= '0;
      seg_reg       <= '0;
      trig_seen_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      base_reg      <= base_next;
      off_reg       <= off_next;
      post_reg      <= post_next;
      seg_reg       <= seg_next;
      trig_seen_reg <= trig_seen_next;
    end
  end

  // trigger address table, one entry per segment
  genvar gi;
  for (gi = 0; gi < MAX_SEGS; gi++) begin : g_trig_addr
    always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
        trig_addr_reg[gi] <= '0;
      end else if (rec_trig && seg_reg == GW'(gi)) begin
        trig_addr_reg[gi] <= wr_addr; // R20
      end
    end
  end

  // ****************************************************************
  // sample memory
  // ****************************************************************
  capture_mem_if #(.AW(AW), .SW(SAMPLE_W)) mem_if ();
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;

  assign mem_if.wr_en   = wr_en;
  assign mem_if.wr_addr = wr_addr;
  assign mem_if.wr_data = samp2_reg;
  assign mem_if.rd_addr = rd_ptr_reg;

  capture_ram #(.AW(AW), .SW(SAMPLE_W)) u_ram (
    .clk_in  (clk_in),
    .port_if (mem_if)
  );

  // ****************************************************************
  // register read port
  // ****************************************************************
  // readout walks memory through WRPTR: write sets the address, a read of the
  // data slot returns the word at the previously set address
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              rd_mem_reg;

  always_comb begin
    rd_ptr_next = rd_ptr_reg;
    rdata_next  = '0;
    if (wr_in && reg_hit(addr_in, WRPTR_ADDR)) begin
      rd_ptr_next = wdata_in[AW-1:0];
    end
    if (rd_in) begin
      case (addr_in)
        CTRL_ADDR:     rdata_next = ctrl_reg;
        DEPTH_ADDR:    rdata_next = DATA_W'(depth_reg);
        SEGS_ADDR:     rdata_next = DATA_W'(segs_reg);
        CUSTPOS_ADDR:  rdata_next = DATA_W'(custpos_reg);
        STATUS_ADDR: begin
          rdata_next[STAT_ACTIVE_BIT] = (state_reg == ST_FILL) || (state_reg == ST_POST);
          rdata_next[STAT_DONE_BIT]   = state_reg == ST_DONE;
          rdata_next[STAT_TRIG_BIT]   = trig_seen_reg;
          rdata_next[STAT_SEG_LSB +: GW] = seg_reg;
        end
        TRIGADDR_ADDR: rdata_next = DATA_W'(trig_addr_reg[rd_ptr_reg[GW-1:0]]);
        WRPTR_ADDR:    rdata_next = DATA_W'(wr_addr);
        default:       rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_reg  <= '0;
      rd_ptr_reg <= '0;
      rd_mem_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rd_ptr_reg <= rd_ptr_next;
      rd_mem_reg <= rd_in && addr_in == MEMRD_ADDR;
    end
  end

  // address 7 reads sample memory at the pointer set earlier
  assign rdata_out = rd_mem_reg ? DATA_W'(mem_if.rd_data) : rdata_reg;

  // ****************************************************************
  // status outputs
  // ****************************************************************
  logic done_reg, active_reg;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      done_reg   <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      done_reg   <= state_next == ST_DONE; // R21
      active_reg <= state_next == ST_FILL || state_next == ST_POST;
    end
  end
  assign acq_done_out   = done_reg;
  assign acq_active_out = active_reg;
  assign seg_index_out  = seg_reg;

endmodule

// ==== verif/capture_ctrl_chk.sv ====
// concurrent checks on the acquisition controller ports
`timescale 1ns/1ps
module capture_ctrl_chk
  import capture_pkg::*;
#(
  parameter int SAMPLE_W  = 32,
  parameter int MAX_DEPTH = 131072,
  parameter int MAX_SEGS  = 64
) (
  input wire logic                        clk_in,
  input wire logic                        reset_in,
  input wire logic [ADDR_W-1:0]           addr_in,
  input wire logic [DATA_W-1:0]           wdata_in,
  input wire logic                        wr_in,
  input wire logic                        rd_in,
  input wire logic [DATA_W-1:0]           rdata_out,
  input wire logic [SAMPLE_W-1:0]         sample_in,
  input wire logic                        trigger_in,
  input wire logic                        seg_trigger_in,
  input wire logic                        qualifier_in,
  input wire logic                        acq_done_out,
  input wire logic                        acq_active_out,
  input wire logic [$clog2(MAX_SEGS)-1:0] seg_index_out
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  logic arm_w;
  logic stop_w;
  logic quiet_reg;
  logic quiet_next;
  assign arm_w  = wr_in && addr_in == CTRL_ADDR && wdata_in[CTRL_ARM_BIT];
  assign stop_w = wr_in && addr_in == CTRL_ADDR && wdata_in[CTRL_STOP_BIT];
  // armed and no trigger yet: conservative, any trigger pin clears it
  always_comb begin
    quiet_next = arm_w ? 1'b1 : quiet_reg;
    if (trigger_in || seg_trigger_in || stop_w) begin
      quiet_next = 1'b0;
    end
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      quiet_reg <= 1'b0;
    end else begin
      quiet_reg <= quiet_next;
    end
  end
  // depth zero leaves no room: arm goes straight to done
  logic depth_zero_reg;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      depth_zero_reg <= 1'b0;
    end else if (wr_in && addr_in == DEPTH_ADDR) begin
      depth_zero_reg <= wdata_in == '0;
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence fill_seq; ##2 acq_active_out; endsequence
  sequence finish_seq; ##[0:1] acq_done_out; endsequence
  arm_starts_a: assert property (arm_w && !depth_zero_reg |-> fill_seq)
    else $error("arm did not start capture");
  wrap_wait_a: assert property (quiet_reg && acq_active_out && !stop_w |=> acq_active_out)
    else $error("capture ended without trigger");
  done_hold_a: assert property (acq_done_out && !arm_w |=> acq_done_out)
    else $error("done dropped before rearm");
  done_excl_a: assert property (!(acq_done_out && acq_active_out))
    else $error("done and active together");
  finish_flag_a: assert property ($fell(acq_active_out) && !$past(stop_w) |-> finish_seq)
    else $error("capture ended without done");
  seg_step_a: assert property ($changed(seg_index_out) |->
    seg_index_out == $past(seg_index_out) + 1'b1 || seg_index_out == '0)
    else $error("segment index skipped");
  seg_live_a: assert property ($changed(seg_index_out) && seg_index_out != '0
    |-> $past(acq_active_out))
    else $error("segment advanced while idle");
  depth_cap_a: assert property ($past(rd_in) && $past(addr_in) == DEPTH_ADDR
    |-> rdata_out <= MAX_DEPTH)
    else $error("depth above maximum");
  segs_cap_a: assert property ($past(rd_in) && $past(addr_in) == SEGS_ADDR
    |-> rdata_out != '0 && rdata_out <= MAX_SEGS)
    else $error("segment count out of range");
  reset_idle_a: assert property ($fell(reset_in) |->
    !acq_active_out && !acq_done_out && seg_index_out == '0)
    else $error("not idle after reset");
endmodule

bind capture_ctrl capture_ctrl_chk #(.SAMPLE_W(SAMPLE_W), .MAX_DEPTH(MAX_DEPTH),
  .MAX_SEGS(MAX_SEGS)) chk (.clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .sample_in, .trigger_in, .seg_trigger_in, .qualifier_in, .acq_done_out,
  .acq_active_out, .seg_index_out);

// ==== verif/capture_src.sv ====
// observed-logic model: counting samples, triggers and storage qualifier
`timescale 1ns/1ps
module capture_src #(
  parameter int SAMPLE_W = 32
) (
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  input  wire logic                trig_en_in,
  input  wire logic                seg_en_in,
  input  wire logic                qual_alt_in,
  input  wire logic [SAMPLE_W-1:0] trig_at_in,
  output logic      [SAMPLE_W-1:0] sample_out,
  output logic                     trigger_out,
  output logic                     seg_trigger_out,
  output logic                     qualifier_out
);
  logic [SAMPLE_W-1:0] count_reg;
  logic [SAMPLE_W-1:0] count_next;
  always_comb begin
    count_next = count_reg + 1'b1;
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
  // a new value each cycle makes every stored slot traceable to its cycle
  assign sample_out      = count_reg;
  assign trigger_out     = trig_en_in & (count_reg == trig_at_in);
  assign seg_trigger_out = seg_en_in & (count_reg == trig_at_in);
  assign qualifier_out   = qual_alt_in ? ~count_reg[0] : 1'b1;
endmodule

// ==== verif/capture_ctrl_tb.sv ====
// self-checking bench for the acquisition buffer controller
`timescale 1ns/1ps
module capture_ctrl_tb;
  import capture_pkg::*;
  // ****************************************************************
  // signals and cases
  // ****************************************************************
  localparam logic [3:0] MEM_ADDR = 4'h7;
  typedef struct packed {trig_pos_e pos; logic [7:0] cust; logic [7:0] post;} row_s;
  typedef struct packed {logic [3:0] addr; logic [31:0] val;} reg_row_s;
  // sixteen-entry window: samples kept from the trigger on
  row_s rows [4] = '{'{POS_PRE, 8'h00, 8'h0E}, '{POS_CENTER, 8'h00, 8'h08},
                     '{POS_POST, 8'h00, 8'h02}, '{POS_CUSTOM, 8'h05, 8'h05}};
  reg_row_s regs [5] = '{'{CTRL_ADDR, 32'h0}, '{DEPTH_ADDR, 32'h40}, '{SEGS_ADDR, 32'h1},
                         '{STATUS_ADDR, 32'h0}, '{4'hF, 32'h0}};
  logic        clk_in   = 1'b0;
  logic        reset_in = 1'b1;
  logic [3:0]  addr_in  = 4'h0;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in    = 1'b0;
  logic        rd_in    = 1'b0;
  logic        trig_en  = 1'b0;
  logic        seg_en   = 1'b0;
  logic        qual_alt = 1'b0;
  logic [31:0] trig_at  = 32'h0;
  logic [31:0] rdata_out, sample, s, s1, ta, got;
  logic        trigger, seg_trigger, qualifier, done, active;
  logic [1:0]  seg_index;
  int          fail_count = 0;
  int          n_compared = 0;

  always #5 clk_in = ~clk_in;

  capture_ctrl #(.SAMPLE_W(32), .MAX_DEPTH(64), .MAX_SEGS(4)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sample_in(sample),
    .trigger_in(trigger), .seg_trigger_in(seg_trigger), .qualifier_in(qualifier),
    .acq_done_out(done), .acq_active_out(active), .seg_index_out(seg_index));
  capture_src #(.SAMPLE_W(32)) src (
    .clk_in(clk_in), .reset_in(reset_in), .trig_en_in(trig_en), .seg_en_in(seg_en),
    .qual_alt_in(qual_alt), .trig_at_in(trig_at), .sample_out(sample),
    .trigger_out(trigger), .seg_trigger_out(seg_trigger), .qualifier_out(qualifier));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic exp_mem(input logic [31:0] a, input logic [31:0] exp, input string name);
    logic [31:0] d;
    reg_wr(WRPTR_ADDR, a);
    repeat (2) @(posedge clk_in);
    reg_rd(MEM_ADDR, d);
    check(name, exp, d);
  endtask
  task automatic trig_read(input logic [31:0] seg, output logic [31:0] a);
    reg_wr(WRPTR_ADDR, seg);
    reg_rd(TRIGADDR_ADDR, a);
  endtask
  // let the window wrap, then trigger on an even sample value
  task automatic fire(input logic use_seg, output logic [31:0] v);
    logic [1:0] idx0;
    repeat (40) @(posedge clk_in);
    idx0 = seg_index;
    v = (sample + 32'h8) & ~32'h1;
    trig_at <= v;
    trig_en <= !use_seg;
    seg_en  <= use_seg;
    for (int i = 0; i < 400 && done !== 1'b1 && seg_index === idx0; i++) begin
      @(posedge clk_in);
    end
    trig_en <= 1'b0;
    seg_en  <= 1'b0;
    check("capture progress", 32'h1, {31'h0, done === 1'b1 || seg_index !== idx0});
    if (n_compared != 0 && done !== 1'b1 && seg_index === idx0) begin
      close_out();
    end
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk_in);
    check("outputs in reset", 32'h0, {28'h0, done, active, seg_index});
    reset_in <= 1'b0;
    for (int r = 0; r < 5; r++) begin
      reg_rd(regs[r].addr, got);
      check("register reset value", regs[r].val, got);
    end
    reg_wr(DEPTH_ADDR, 32'h1000);
    reg_wr(SEGS_ADDR, 32'h0);
    reg_rd(DEPTH_ADDR, got);
    check("depth clamp", 32'h40, got);
    reg_rd(SEGS_ADDR, got);
    check("segment count floor", 32'h1, got);
    reg_wr(DEPTH_ADDR, 32'h10);
    for (int r = 0; r < 4; r++) begin
      reg_wr(CUSTPOS_ADDR, {24'h0, rows[r].cust});
      reg_wr(CTRL_ADDR, {28'h0, rows[r].pos, 2'b01});
      fire(1'b0, s);
      trig_read(32'h0, ta);
      exp_mem(ta, s, "trigger sample");
      exp_mem((ta + rows[r].post - 1) & 32'hF, s + rows[r].post - 1, "newest");
      exp_mem((ta + rows[r].post) & 32'hF, s + rows[r].post - 32'h10, "oldest");
    end
    qual_alt <= 1'b1;
    reg_wr(CTRL_ADDR, 32'h19);
    fire(1'b0, s);
    trig_read(32'h0, ta);
    exp_mem(ta, s, "qualified trigger");
    exp_mem((ta + 1) & 32'hF, s + 32'h2, "next kept");
    exp_mem((ta - 1) & 32'hF, s - 32'h2, "previous kept");
    qual_alt <= 1'b0;
    reg_wr(SEGS_ADDR, 32'h2);
    reg_wr(CTRL_ADDR, 32'hB);
    repeat (12) @(posedge clk_in);
    trig_at <= sample + 32'h4;
    trig_en <= 1'b1;
    repeat (12) @(posedge clk_in);
    trig_en <= 1'b0;
    check("plain trigger ignored", 32'h4, {29'h0, active, seg_index});
    fire(1'b1, s);
    check("segment index", 32'h1, {30'h0, seg_index});
    fire(1'b1, s1);
    trig_read(32'h0, ta);
    check("segment 0 range", 32'h0, ta >> 3);
    exp_mem(ta, s, "segment 0 trigger");
    exp_mem((ta + 1) & 32'h7, s - 32'h7, "segment 0 oldest");
    trig_read(32'h1, ta);
    check("segment 1 range", 32'h1, ta >> 3);
    exp_mem(ta, s1, "segment 1 trigger");
    check("done held", 32'h1, {31'h0, done});
    reg_rd(STATUS_ADDR, got);
    check("status after segments", 32'h0000_0106, got);
    reg_wr(CTRL_ADDR, 32'h1);
    repeat (3) @(posedge clk_in);
    #1 check("done cleared by arm", 32'h0, {31'h0, done});
    reg_wr(CTRL_ADDR, 32'h20);
    #1 check("stop ends capture", 32'h2, {30'h0, done, active});
    close_out();
  end
endmodule
